/* File: tec_pkg.sv */
// Shared constants and carrier types for the TLP error checker
package tec_pkg;
  // Register byte offsets on the AHB-Lite slave
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DEVCTL = 8'h04;
  localparam logic [7:0] ADDR_RX_MAP = 8'h08;
  localparam logic [7:0] ADDR_TX_MAP = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_ERRCNT = 8'h14;
  // Field positions
  localparam int CTRL_DOWNSTREAM = 0;
  localparam int CTRL_D3HOT = 1;
  localparam int CTRL_ECRC_LSB = 4;
  localparam int DEVCTL_MPS_LSB = 5;
  localparam int STAT_CODE_LSB = 4;
  // Reset values
  localparam logic [31:0] RST_CTRL = 32'h0000_0000;
  localparam logic [2:0] RST_MPS = 3'h0;
  localparam logic [7:0] RST_TC_MAP = 8'hff;
  // Formation constants
  localparam logic [10:0] MPS_BASE_DW = 11'h020;
  localparam logic [10:0] MAX_LEN_DW = 11'h400;
  localparam logic [9:0] ONE_DW = 10'h001;
  localparam logic [11:0] HDR3_DW = 12'h003;
  localparam logic [11:0] HDR4_DW = 12'h004;
  localparam logic [11:0] ECRC_DW = 12'h001;
  // Type field codes
  localparam logic [4:0] TYP_MEM = 5'h00;
  localparam logic [4:0] TYP_MEMLK = 5'h01;
  localparam logic [4:0] TYP_IO = 5'h02;
  localparam logic [4:0] TYP_CFG0 = 5'h04;
  localparam logic [4:0] TYP_CFG1 = 5'h05;
  localparam logic [4:0] TYP_CPL = 5'h0a;
  localparam logic [4:0] TYP_CPLLK = 5'h0b;
  localparam logic [1:0] TYP_MSG_HI = 2'h2;
  // Message routing subfield
  localparam logic [2:0] RT_TO_RC = 3'h0;
  localparam logic [2:0] RT_BCAST = 3'h3;
  localparam logic [2:0] RT_LOCAL = 3'h4;
  localparam logic [2:0] RT_GATHER = 3'h5;
  // Message codes
  localparam logic [7:0] MC_UNLOCK = 8'h00;
  localparam logic [7:0] MC_PM_NAK = 8'h14;
  localparam logic [7:0] MC_PM_PME = 8'h18;
  localparam logic [7:0] MC_PME_OFF = 8'h19;
  localparam logic [7:0] MC_PME_ACK = 8'h1b;
  localparam logic [4:0] MC_INTX_HI = 5'h04;
  localparam logic [7:0] MC_ERR_COR = 8'h30;
  localparam logic [7:0] MC_ERR_NF = 8'h31;
  localparam logic [7:0] MC_ERR_FAT = 8'h33;
  localparam logic [7:0] MC_SPL = 8'h50;
  localparam logic [7:0] MC_VDM0 = 8'h7e;
  localparam logic [7:0] MC_VDM1 = 8'h7f;

  typedef enum logic [2:0] {
    ERR_NONE, ERR_ECRC, ERR_MAL_RX, ERR_UR, ERR_VDM_DROP, ERR_MAL_TX
  } tec_err_type;

  typedef struct packed {
    logic valid;
    logic from_link;
    logic intermediate;
    logic targets_bridge;
    logic heading_down;
    logic claimed;
    logic [1:0] func;
    logic [1:0] fmt;
    logic [4:0] typ;
    logic [2:0] tc;
    logic [1:0] attr;
    logic td;
    logic ep;
    logic [9:0] len;
    logic [3:0] last_be;
    logic [7:0] msg_code;
    logic [10:0] payload_dw;
    logic [11:0] total_dw;
    logic ecrc_ok;
    logic non_posted;
  } tec_rx_tlp_type;

  typedef struct packed {
    logic valid;
    logic [2:0] tc;
  } tec_tx_tlp_type;

  typedef struct packed {
    logic valid;
    tec_err_type code;
    logic log_aer;
    logic nullify;
    logic drop;
    logic ur_cpl;
    logic [1:0] cpl_func;
  } tec_result_type;
endpackage

/* File: tec_checker.sv */
// Receive and transmit TLP error checker with AHB-Lite register slave
//
// Implementation choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module tec_checker #(
  parameter int FUNCS = 4
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic link_up_in,
  input wire tec_pkg::tec_rx_tlp_type rx_tlp_in,
  input wire tec_pkg::tec_tx_tlp_type tx_tlp_in,
  output logic ecrc_check_out,
  output tec_pkg::tec_result_type rx_result_out,
  output tec_pkg::tec_result_type tx_result_out
);

  // Registers
  logic [31:0] ctrl_ff;
  logic [2:0] mps_ff;
  logic [7:0] rx_map_ff;
  logic [7:0] tx_map_ff;
  logic [15:0] err_cnt_ff;
  tec_pkg::tec_err_type last_code_ff;
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  tec_pkg::tec_result_type rx_res_ff;
  tec_pkg::tec_result_type tx_res_ff;
  logic [31:0] rdata_ff;

  function automatic logic [10:0] len_dw(input logic [9:0] len);
    len_dw = (len == 10'h000) ? tec_pkg::MAX_LEN_DW : {1'b0, len};
  endfunction

  function automatic logic map_has(input logic [7:0] map, input logic [2:0] tc);
    map_has = map[tc];
  endfunction

  // AHB-Lite decode; the slave never inserts wait states
  wire ahb_go = hsel_in & hready_in & htrans_in[1];
  wire ahb_wr = ahb_go & hwrite_in;
  wire ahb_rd = ahb_go & ~hwrite_in;
  wire [7:0] ahb_off = haddr_in[7:0];
  wire addr_hit = (haddr_in[31:8] == 24'h00_0000) & (ahb_off[1:0] == 2'h0);

  // Configuration views
  wire downstream = ctrl_ff[tec_pkg::CTRL_DOWNSTREAM];
  wire d3hot = ctrl_ff[tec_pkg::CTRL_D3HOT];
  wire [FUNCS-1:0] func_ecrc = ctrl_ff[tec_pkg::CTRL_ECRC_LSB +: FUNCS];
  // port enable is OR of functions
  wire port_ecrc = |func_ecrc;
  // Last error code sits in its own field above the two live status bits
  wire [31:0] status_word = (32'(last_code_ff) << tec_pkg::STAT_CODE_LSB) |
    {30'h0000_0000, port_ecrc, link_up_in};
  wire [31:0] rd_mux =
    !addr_hit ? 32'h0000_0000 :
    (ahb_off == tec_pkg::ADDR_CTRL) ? ctrl_ff :
    (ahb_off == tec_pkg::ADDR_DEVCTL) ? 32'(mps_ff) << tec_pkg::DEVCTL_MPS_LSB :
    (ahb_off == tec_pkg::ADDR_RX_MAP) ? {24'h00_0000, rx_map_ff} :
    (ahb_off == tec_pkg::ADDR_TX_MAP) ? {24'h00_0000, tx_map_ff} :
    (ahb_off == tec_pkg::ADDR_STATUS) ? status_word :
    (ahb_off == tec_pkg::ADDR_ERRCNT) ? {16'h0000, err_cnt_ff} : 32'h0000_0000;

  // Header decode
  wire rx_v = rx_tlp_in.valid;
  wire [1:0] fmt = rx_tlp_in.fmt;
  wire [4:0] typ = rx_tlp_in.typ;
  wire [2:0] rt = typ[2:0];
  wire [7:0] mc = rx_tlp_in.msg_code;
  wire is_msg = (typ[4:3] == tec_pkg::TYP_MSG_HI);
  wire is_io = (typ == tec_pkg::TYP_IO);
  wire is_cfg = (typ == tec_pkg::TYP_CFG0) | (typ == tec_pkg::TYP_CFG1);
  wire is_mem = (typ == tec_pkg::TYP_MEM);
  wire is_cpl = (typ == tec_pkg::TYP_CPL) | (typ == tec_pkg::TYP_CPLLK);
  wire has_data = fmt[1];
  wire rt_legal = (rt <= tec_pkg::RT_GATHER);
  wire fmt_type_ok =
    is_mem | ((typ == tec_pkg::TYP_MEMLK) & ~has_data) |
    ((is_io | is_cfg | is_cpl) & ~fmt[0]) | (is_msg & fmt[0] & rt_legal);
  wire is_intx = is_msg & (mc[7:3] == tec_pkg::MC_INTX_HI);
  wire is_pm = is_msg & ((mc == tec_pkg::MC_PM_NAK) | (mc == tec_pkg::MC_PM_PME) |
    (mc == tec_pkg::MC_PME_OFF) | (mc == tec_pkg::MC_PME_ACK));
  wire is_errmsg = is_msg & ((mc == tec_pkg::MC_ERR_COR) | (mc == tec_pkg::MC_ERR_NF) |
    (mc == tec_pkg::MC_ERR_FAT));
  wire is_unlock = is_msg & (mc == tec_pkg::MC_UNLOCK);
  wire is_spl = is_msg & (mc == tec_pkg::MC_SPL);
  wire is_vdm0 = is_msg & (mc == tec_pkg::MC_VDM0);
  wire is_vdm1 = is_msg & (mc == tec_pkg::MC_VDM1);
  wire mc_known = is_intx | is_pm | is_errmsg | is_unlock | is_spl | is_vdm0 | is_vdm1;

  // ingress checks gated by reception from the link
  wire chk_en = rx_v & rx_tlp_in.from_link;
  wire m_fmt = ~fmt_type_ok;
  // maximum payload size
  // Wide enough that the largest size codes do not wrap to zero
  wire [13:0] mps_dw = 14'(tec_pkg::MPS_BASE_DW) << mps_ff;
  wire m_mps = has_data & (rx_tlp_in.payload_dw > mps_dw);
  wire m_len = has_data & (len_dw(rx_tlp_in.len) != rx_tlp_in.payload_dw);
  wire [11:0] hdr_dw = fmt[0] ? tec_pkg::HDR4_DW : tec_pkg::HDR3_DW;
  wire [11:0] calc_dw = hdr_dw + {1'b0, rx_tlp_in.payload_dw} + tec_pkg::ECRC_DW;
  wire m_td = rx_tlp_in.td & (calc_dw != rx_tlp_in.total_dw);
  wire m_iocfg = (is_io | is_cfg) & ((rx_tlp_in.len != tec_pkg::ONE_DW) |
    (rx_tlp_in.tc != 3'h0) | (rx_tlp_in.attr != 2'h0) | (rx_tlp_in.last_be != 4'h0));
  wire m_msgtc = (is_intx | is_pm | is_errmsg | is_unlock | is_spl) & (rx_tlp_in.tc != 3'h0);
  wire m_dir = is_msg & (((rt == tec_pkg::RT_TO_RC) & ~downstream) |
    ((rt == tec_pkg::RT_BCAST) & downstream));
  wire m_gather = is_msg & (rt == tec_pkg::RT_GATHER) &
    (~downstream | (mc != tec_pkg::MC_PME_ACK));
  wire m_intx = is_intx & ~downstream;
  wire m_rxmap = ~map_has(rx_map_ff, rx_tlp_in.tc);
  // Shape checks that need a legal type field are held off when it is not
  wire malformed = chk_en & (m_fmt | (fmt_type_ok & (m_mps | m_len | m_td | m_iocfg |
    m_msgtc | m_dir | m_gather | m_intx | m_rxmap)));

  // CRC checked only on digest TLPs while the port is enabled
  wire ecrc_check = rx_v & port_ecrc & rx_tlp_in.td;
  wire ecrc_fail = ecrc_check & ~rx_tlp_in.ecrc_ok;
  wire ecrc_func_en = func_ecrc[rx_tlp_in.func[$clog2(FUNCS)-1:0]];
  // intermediate without link reception is not logged
  wire ecrc_log = ecrc_func_en & ~(rx_tlp_in.intermediate & ~rx_tlp_in.from_link);

  // Requests aimed at the bridge, and downstream-heading requests on a downstream port while the link is down
  wire tgt = rx_v & rx_tlp_in.targets_bridge & ~is_cpl;
  wire u_vdm0 = tgt & is_vdm0;
  wire vdm1_drop = tgt & is_vdm1;
  wire u_badmc = tgt & is_msg & ~mc_known;
  wire u_poison = tgt & rx_tlp_in.ep & has_data & (is_io | is_mem |
    (is_msg & ~is_vdm0 & ~is_vdm1));
  wire u_d3 = tgt & d3hot;
  wire u_link = rx_v & downstream & ~link_up_in & rx_tlp_in.heading_down & ~is_cpl;
  wire unsup = u_vdm0 | u_badmc | u_poison | u_d3 | u_link;

  // ECRC outranks malformed, which outranks unsupported
  tec_pkg::tec_result_type nxt_rx_res;
  always_comb begin
    nxt_rx_res = '0;
    nxt_rx_res.valid = rx_v & ((ecrc_fail & ecrc_log) | malformed | unsup | vdm1_drop);
    if (ecrc_fail && ecrc_log) begin
      nxt_rx_res.code = tec_pkg::ERR_ECRC;
      nxt_rx_res.log_aer = 1'b1;
    end else if (malformed) begin
      nxt_rx_res.code = tec_pkg::ERR_MAL_RX;
      nxt_rx_res.log_aer = 1'b1;
      nxt_rx_res.nullify = 1'b1;
    end else if (unsup) begin
      nxt_rx_res.code = tec_pkg::ERR_UR;
      nxt_rx_res.log_aer = 1'b1;
      nxt_rx_res.drop = 1'b1;
      nxt_rx_res.ur_cpl = rx_tlp_in.non_posted;
      nxt_rx_res.cpl_func = rx_tlp_in.claimed ? rx_tlp_in.func : 2'h0;
    end else if (vdm1_drop) begin
      nxt_rx_res.code = tec_pkg::ERR_VDM_DROP;
      nxt_rx_res.drop = 1'b1;
    end else begin
      nxt_rx_res.code = tec_pkg::ERR_NONE;
    end
  end

  // egress check on every sent packet
  wire tx_bad = tx_tlp_in.valid & ~map_has(tx_map_ff, tx_tlp_in.tc);
  tec_pkg::tec_result_type nxt_tx_res;
  always_comb begin
    nxt_tx_res = '0;
    nxt_tx_res.valid = tx_bad;
    nxt_tx_res.code = tx_bad ? tec_pkg::ERR_MAL_TX : tec_pkg::ERR_NONE;
    nxt_tx_res.log_aer = tx_bad;
    nxt_tx_res.nullify = tx_bad;
  end

  wire nxt_any_err = nxt_rx_res.valid | nxt_tx_res.valid;
  wire [15:0] nxt_err_cnt = err_cnt_ff + 16'(nxt_rx_res.valid) + 16'(nxt_tx_res.valid);
  wire [31:0] nxt_ctrl = hwdata_in & (32'(((1 << FUNCS) - 1)) << tec_pkg::CTRL_ECRC_LSB |
    32'h0000_0003);

  // Bus side
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      rdata_ff <= 32'h0000_0000;
    end else begin
      wr_pend_ff <= ahb_wr & addr_hit;
      wr_addr_ff <= ahb_off;
      if (ahb_rd) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_ff <= tec_pkg::RST_CTRL;
      mps_ff <= tec_pkg::RST_MPS;
      rx_map_ff <= tec_pkg::RST_TC_MAP;
      tx_map_ff <= tec_pkg::RST_TC_MAP;
    end else if (wr_pend_ff) begin
      if (wr_addr_ff == tec_pkg::ADDR_CTRL) begin
        ctrl_ff <= nxt_ctrl;
      end
      if (wr_addr_ff == tec_pkg::ADDR_DEVCTL) begin
        mps_ff <= hwdata_in[tec_pkg::DEVCTL_MPS_LSB +: 3];
      end
      if (wr_addr_ff == tec_pkg::ADDR_RX_MAP) begin
        rx_map_ff <= hwdata_in[7:0];
      end
      if (wr_addr_ff == tec_pkg::ADDR_TX_MAP) begin
        tx_map_ff <= hwdata_in[7:0];
      end
    end
  end

  // Checker outputs; one cycle after the TLP is presented
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      rx_res_ff <= '0;
      tx_res_ff <= '0;
      err_cnt_ff <= 16'h0000;
      last_code_ff <= tec_pkg::ERR_NONE;
    end else begin
      rx_res_ff <= nxt_rx_res;
      tx_res_ff <= nxt_tx_res;
      // Counter saturates so software never sees a wrap as a clean state
      if (nxt_any_err && (err_cnt_ff < 16'hfffe)) begin
        err_cnt_ff <= (nxt_err_cnt > 16'hfffe) ? 16'hfffe : nxt_err_cnt;
      end
      if (nxt_rx_res.valid) begin
        last_code_ff <= nxt_rx_res.code;
      end else if (nxt_tx_res.valid) begin
        last_code_ff <= nxt_tx_res.code;
      end
    end
  end

  assign hrdata_out = rdata_ff;
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign ecrc_check_out = ecrc_check;
  assign rx_result_out = rx_res_ff;
  assign tx_result_out = tx_res_ff;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  chk_port_ecrc_or: assert property (ecrc_check_out |-> (|func_ecrc) && rx_tlp_in.td)
    else $error("ECRC checked without digest or port enable");
  chk_ecrc_func_gate: assert property ($past(ecrc_fail && !ecrc_func_en) |->
    rx_result_out.code != tec_pkg::ERR_ECRC)
    else $error("ECRC logged for disabled function");
  chk_ecrc_no_link: assert property ($past(rx_v && rx_tlp_in.intermediate && !rx_tlp_in.from_link)
    |-> rx_result_out.code != tec_pkg::ERR_ECRC)
    else $error("ECRC logged for non-link intermediate");
  chk_vdm1_silent: assert property (rx_v && vdm1_drop && !malformed && !unsup && !ecrc_fail
    |=> rx_result_out.drop && !rx_result_out.log_aer)
    else $error("Vendor type 1 not silently dropped");
  chk_vdm0_unsup: assert property (u_vdm0 && !malformed && !ecrc_fail |=>
    rx_result_out.code == tec_pkg::ERR_UR)
    else $error("Vendor type 0 not unsupported");
  chk_d3_unsup: assert property (u_d3 && !malformed && !ecrc_fail |=>
    rx_result_out.code == tec_pkg::ERR_UR)
    else $error("D3hot request not unsupported");
  chk_link_down: assert property (u_link && !malformed && !ecrc_fail |=>
    rx_result_out.code == tec_pkg::ERR_UR)
    else $error("Link-down TLP not unsupported");
  chk_malformed_null: assert property (rx_result_out.code == tec_pkg::ERR_MAL_RX |->
    rx_result_out.nullify && rx_result_out.log_aer && $past(rx_tlp_in.from_link))
    else $error("Malformed TLP not nullified and logged");
  chk_ur_cpl_func: assert property (u_badmc && !malformed && !ecrc_fail && rx_tlp_in.non_posted
    && !rx_tlp_in.claimed |=> rx_result_out.ur_cpl && rx_result_out.cpl_func == 2'h0)
    else $error("Unclaimed UR completion not from function 0");
  chk_tx_map: assert property (tx_tlp_in.valid |=>
    tx_result_out.valid == !$past(tx_map_ff[tx_tlp_in.tc]))
    else $error("Egress class map check wrong");
  chk_pulse_single: assert property (rx_result_out.valid && !$past(rx_v) |-> 1'b0)
    else $error("Error pulse without a TLP");
  chk_intx_up: assert property (chk_en && fmt_type_ok && is_intx && !downstream |=>
    rx_result_out.code == tec_pkg::ERR_MAL_RX || rx_result_out.code == tec_pkg::ERR_ECRC)
    else $error("INTx on upstream port accepted");

  cov_ecrc_err: cover property (rx_result_out.valid && rx_result_out.code == tec_pkg::ERR_ECRC);
  cov_mal_rx: cover property (rx_result_out.valid && rx_result_out.code == tec_pkg::ERR_MAL_RX);
  cov_ur_cpl: cover property (rx_result_out.ur_cpl);
  cov_tx_bad: cover property (tx_result_out.valid);
endmodule
`default_nettype wire

/* File: tec_link_partner.sv */
// Link partner model that presents TLP descriptors to the checker
`timescale 1ns/10ps
`default_nettype none
module tec_link_partner (
  input wire logic clk_sys_in,
  output var tec_pkg::tec_rx_tlp_type rx_tlp_out,
  output var tec_pkg::tec_tx_tlp_type tx_tlp_out
);
  initial begin
    rx_tlp_out = '0;
    tx_tlp_out = '0;
  end
  // Between packets the fields show inverted junk, never a stale copy
  task automatic send_rx(input tec_pkg::tec_rx_tlp_type d);
    @(posedge clk_sys_in);
    rx_tlp_out <= d;
    @(posedge clk_sys_in);
    rx_tlp_out <= {1'b0, ~d[$bits(d)-2:0]};
  endtask
  task automatic send_tx(input logic [2:0] tc);
    @(posedge clk_sys_in);
    tx_tlp_out <= {1'b1, tc};
    @(posedge clk_sys_in);
    tx_tlp_out <= {1'b0, ~tc};
  endtask
endmodule
`default_nettype wire

/* File: tb_tlp_error_checker.sv */
// Self-checking testbench for the TLP error checker
`timescale 1ns/10ps
`default_nettype none
module tb_tlp_error_checker;
  logic clk_sys_in, rst_in, hsel, hwrite, hrdy, hresp, link_up, ecrc_chk;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, ctrl, devctl, rxmap, txmap, x;
  tec_pkg::tec_rx_tlp_type rx, d;
  tec_pkg::tec_tx_tlp_type tx;
  tec_pkg::tec_result_type rres, tres;
  int miscompares, num_checks, n_errs;
  tec_pkg::tec_err_type lastc;

  tec_checker #(.FUNCS(4)) uut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hrdy),
    .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp), .link_up_in(link_up), .rx_tlp_in(rx),
    .tx_tlp_in(tx), .ecrc_check_out(ecrc_chk), .rx_result_out(rres), .tx_result_out(tres));
  tec_link_partner p (.clk_sys_in(clk_sys_in), .rx_tlp_out(rx), .tx_tlp_out(tx));

  initial begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // The slave never stretches today, but the master must not rely on that
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (hrdy !== 1'b1 && n < 20);
    if (hrdy !== 1'b1) chk("hready", 32'h1, hrdy);
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
    @(posedge clk_sys_in);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    r = hrdata;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk("register", e, r);
    chk("hresp", 32'h0, hresp);
  endtask

  function automatic tec_pkg::tec_result_type exp_rx(input tec_pkg::tec_rx_tlp_type t);
    tec_pkg::tec_result_type e;
    logic msg, io, cpl, ds, intx, cls, vdm, bad, mal, ur, fail, lg;
    logic [7:0] mc;
    logic [11:0] ldw;
    e = '0;
    mc = t.msg_code;
    ds = ctrl[tec_pkg::CTRL_DOWNSTREAM];
    msg = t.typ[4:3] == tec_pkg::TYP_MSG_HI;
    io = t.typ inside {tec_pkg::TYP_IO, tec_pkg::TYP_CFG0, tec_pkg::TYP_CFG1};
    cpl = t.typ inside {tec_pkg::TYP_CPL, tec_pkg::TYP_CPLLK};
    intx = mc[7:3] == tec_pkg::MC_INTX_HI;
    vdm = mc inside {tec_pkg::MC_VDM0, tec_pkg::MC_VDM1};
    cls = intx || mc inside {tec_pkg::MC_UNLOCK, tec_pkg::MC_PM_NAK, tec_pkg::MC_PM_PME, tec_pkg::MC_PME_OFF,
      tec_pkg::MC_PME_ACK, tec_pkg::MC_ERR_COR, tec_pkg::MC_ERR_NF, tec_pkg::MC_ERR_FAT, tec_pkg::MC_SPL};
    bad = !(msg || io || cpl || t.typ inside {tec_pkg::TYP_MEM, tec_pkg::TYP_MEMLK});
    ldw = (t.len == 10'h0) ? 12'(tec_pkg::MAX_LEN_DW) : 12'(t.len);
    mal = bad || 13'(t.payload_dw) > (13'(tec_pkg::MPS_BASE_DW) << devctl[7:5])
      || (t.fmt[1] && ldw != 12'(t.payload_dw)) || (t.td && t.total_dw != (t.fmt[0] ? tec_pkg::HDR4_DW
      : tec_pkg::HDR3_DW) + 12'(t.fmt[1] ? t.payload_dw : 11'h0) + tec_pkg::ECRC_DW)
      || (io && (t.len != tec_pkg::ONE_DW || t.tc != 3'h0 || t.attr != 2'h0 || t.last_be != 4'h0))
      || (msg && ((cls && t.tc != 3'h0) || (intx && !ds) || (t.typ[2:0] == tec_pkg::RT_TO_RC && !ds)
      || (t.typ[2:0] == tec_pkg::RT_BCAST && ds)
      || (t.typ[2:0] == tec_pkg::RT_GATHER && !(ds && mc == tec_pkg::MC_PME_ACK)))) || !rxmap[t.tc];
    ur = !cpl && t.targets_bridge && ((msg && (mc == tec_pkg::MC_VDM0 || !(cls || vdm))) || ctrl[1]
      || (t.ep && t.fmt[1] && (t.typ inside {tec_pkg::TYP_IO, tec_pkg::TYP_MEM} || (msg && !vdm))));
    ur = ur || (!cpl && ds && !link_up && t.heading_down);
    fail = t.td && |ctrl[7:4] && !t.ecrc_ok;
    lg = ctrl[4 + t.func] && !(t.intermediate && !t.from_link);
    e.code = (fail && lg) ? tec_pkg::ERR_ECRC : (mal && t.from_link) ? tec_pkg::ERR_MAL_RX
      : ur ? tec_pkg::ERR_UR : (!cpl && t.targets_bridge && msg && mc == tec_pkg::MC_VDM1)
      ? tec_pkg::ERR_VDM_DROP : tec_pkg::ERR_NONE;
    e.valid = e.code != tec_pkg::ERR_NONE;
    e.log_aer = e.code inside {tec_pkg::ERR_ECRC, tec_pkg::ERR_MAL_RX, tec_pkg::ERR_UR};
    e.nullify = e.code == tec_pkg::ERR_MAL_RX;
    e.drop = e.code inside {tec_pkg::ERR_UR, tec_pkg::ERR_VDM_DROP};
    e.ur_cpl = e.code == tec_pkg::ERR_UR && t.non_posted;
    e.cpl_func = (e.code == tec_pkg::ERR_UR && t.claimed) ? t.func : 2'h0;
    return e;
  endfunction

  function automatic tec_pkg::tec_rx_tlp_type rnd_rx();
    tec_pkg::tec_rx_tlp_type r;
    logic [95:0] b;
    logic [4:0] ty [8];
    logic [7:0] mc [13];
    int k;
    ty = '{tec_pkg::TYP_MEM, tec_pkg::TYP_MEMLK, tec_pkg::TYP_IO, tec_pkg::TYP_CFG0, tec_pkg::TYP_CFG1,
      tec_pkg::TYP_CPL, tec_pkg::TYP_CPLLK, {tec_pkg::TYP_MSG_HI, 3'($urandom % 6)}};
    mc = '{tec_pkg::MC_UNLOCK, tec_pkg::MC_PM_NAK, tec_pkg::MC_PM_PME, tec_pkg::MC_PME_OFF, tec_pkg::MC_PME_ACK,
      tec_pkg::MC_ERR_COR, tec_pkg::MC_ERR_NF, tec_pkg::MC_ERR_FAT, tec_pkg::MC_SPL, tec_pkg::MC_VDM0,
      tec_pkg::MC_VDM1, {tec_pkg::MC_INTX_HI, 3'h1}, 8'h01};
    b = {$urandom, $urandom, $urandom};
    r = b[$bits(r)-1:0];
    k = $urandom % 8;
    r.valid = 1'b1;
    r.typ = ty[k];
    if (k == 1) r.fmt[1] = 1'b0;
    if (k inside {[2:6]}) r.fmt[0] = 1'b0;
    if (k == 7) r.fmt[0] = 1'b1;
    r.msg_code = mc[$urandom % 13];
    r.len = 10'($urandom % 3 + 1);
    r.payload_dw = r.fmt[1] ? 11'(r.len) + 11'($urandom % 4 == 0) : 11'h0;
    r.total_dw = (r.fmt[0] ? tec_pkg::HDR4_DW : tec_pkg::HDR3_DW) + 12'(r.payload_dw) + 12'($urandom % 4 != 0);
    if ($urandom % 2) {r.tc, r.attr, r.last_be} = 9'h0;
    r.ecrc_ok = $urandom % 4 != 0;
    return r;
  endfunction

  task automatic run_rx(input tec_pkg::tec_rx_tlp_type t);
    tec_pkg::tec_result_type e;
    fork
      p.send_rx(t);
      begin
        @(posedge clk_sys_in);
        // Expectation taken just after the edge that drives the TLP; the link state was driven one edge earlier
        #1 e = exp_rx(t);
        chk("ecrc_check", t.td && |ctrl[7:4], ecrc_chk);
      end
    join
    #1;
    chk("rx_valid", e.valid, rres.valid);
    chk("rx_code", e.code, rres.code);
    chk("rx_flags", {e.log_aer, e.nullify, e.drop, e.ur_cpl, e.cpl_func},
      {rres.log_aer, rres.nullify, rres.drop, rres.ur_cpl, rres.cpl_func});
    if (e.valid) begin
      n_errs++;
      lastc = e.code;
    end
  endtask

  task automatic run_tx(input logic [2:0] tc);
    p.send_tx(tc);
    #1 chk("tx_valid", !txmap[tc], tres.valid);
    chk("tx_code", !txmap[tc] ? tec_pkg::ERR_MAL_TX : tec_pkg::ERR_NONE, tres.code);
    chk("tx_flags", {2{!txmap[tc]}}, {tres.log_aer, tres.nullify});
    if (!txmap[tc]) begin
      n_errs++;
      lastc = tec_pkg::ERR_MAL_TX;
    end
  endtask

  initial begin
    #200000;
    miscompares++;
    complete_run();
  end

  initial begin
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    rst_in = 1'b1;
    link_up = 1'b1;
    {ctrl, devctl, rxmap, txmap} = {64'h0, 32'hff, 32'hff};
    miscompares = 0;
    num_checks = 0;
    n_errs = 0;
    lastc = tec_pkg::ERR_NONE;
    void'($urandom(32'h96ee));
    repeat (6) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    rdc(tec_pkg::ADDR_CTRL, 32'h0);
    rdc(tec_pkg::ADDR_DEVCTL, 32'h0);
    rdc(tec_pkg::ADDR_RX_MAP, 32'hff);
    rdc(tec_pkg::ADDR_TX_MAP, 32'hff);
    rdc(tec_pkg::ADDR_STATUS, 32'h1);
    rdc(tec_pkg::ADDR_ERRCNT, 32'h0);
    // Unmapped write must read back as zero and leave CTRL alone
    ahb(1'b1, 8'h20, 32'hffff_ffff, x);
    rdc(8'h20, 32'h0);
    rdc(tec_pkg::ADDR_CTRL, 32'h0);
    for (int c = 0; c < 4; c++) begin
      ctrl = {24'h0, 4'($urandom), 2'b00, 2'(c)};
      devctl = {24'h0, 3'($urandom % 2), 5'h0};
      rxmap = {24'h0, 8'($urandom) | 8'h01};
      txmap = {24'h0, 8'($urandom)};
      ahb(1'b1, tec_pkg::ADDR_CTRL, ctrl, x);
      ahb(1'b1, tec_pkg::ADDR_DEVCTL, devctl, x);
      ahb(1'b1, tec_pkg::ADDR_RX_MAP, rxmap, x);
      ahb(1'b1, tec_pkg::ADDR_TX_MAP, txmap, x);
      rdc(tec_pkg::ADDR_CTRL, ctrl);
      ahb(1'b0, tec_pkg::ADDR_STATUS, 32'h0, x);
      chk("status", {|ctrl[7:4], link_up}, x[1:0]);
      for (int t = 0; t < 8; t++) run_tx(3'(t));
      for (int n = 0; n < 80; n++) begin
        repeat ($urandom % 3 + 1) @(posedge clk_sys_in);
        link_up <= 1'($urandom);
        run_rx(rnd_rx());
      end
    end
    // Clean memory write at the payload limit, then just above it
    ctrl = 32'h21;
    devctl = 32'h0;
    rxmap = 32'hff;
    ahb(1'b1, tec_pkg::ADDR_CTRL, ctrl, x);
    ahb(1'b1, tec_pkg::ADDR_DEVCTL, devctl, x);
    ahb(1'b1, tec_pkg::ADDR_RX_MAP, rxmap, x);
    @(posedge clk_sys_in);
    link_up <= 1'b1;
    d = '0;
    {d.valid, d.from_link, d.ecrc_ok, d.fmt, d.typ} = {3'b111, 2'b10, tec_pkg::TYP_MEM};
    {d.len, d.payload_dw, d.total_dw} = {10'd32, 11'd32, 12'd36};
    run_rx(d);
    {d.len, d.payload_dw} = {10'd33, 11'd33};
    run_rx(d);
    d.typ = 5'h1f;
    run_rx(d);
    {d.typ, d.len, d.payload_dw, d.td, d.ecrc_ok, d.func} = {tec_pkg::TYP_MEM, 10'd32, 11'd32, 2'b10, 2'h1};
    run_rx(d);
    d.func = 2'h2;
    run_rx(d);
    {d.func, d.intermediate, d.from_link} = {2'h1, 2'b10};
    run_rx(d);
    rdc(tec_pkg::ADDR_ERRCNT, 32'(n_errs));
    rdc(tec_pkg::ADDR_STATUS, {25'h0, 3'(lastc), 2'b00, |ctrl[7:4], link_up});
    complete_run();
  end
endmodule
`default_nettype wire
